// ===== mpd_top.sv
// What this block does
// [RULE1] Eleven modulated outputs: ten of 8-bit and one of 14-bit resolution.
// [RULE2] An 8-bit channel drives its pin only when its pin-select bit is set.
// [RULE3] One polarity bit in function control inverts all 8-bit channels.
// [RULE4] An 8-bit pulse lasts as many quarter-clock ticks as its duty value.
// [RULE5] An 8-bit channel repeats every 256 ticks, clock divided by 1024.
// [RULE6] The 14-bit pin is driven only when bit 0 of enable-second is 1.
// [RULE7] The working latch loads both 7-bit latches when coarse is written.
// [RULE8] Upper seven bits set coarse width, lower seven pick fine subperiods.
// [RULE9] Coarse and fine outputs are ORed to form the 14-bit output.
// [RULE10] The 14-bit output is inverted when its polarity bit is 1.
// [RULE11] The 14-bit counter steps every 4 clocks; subperiods span 128 ticks.
// [RULE12] The fine pattern repeats after 128 subperiods.
// [RULE13] Coarse pulse starts each subperiod, coarse value times four clocks.
// [RULE14] Fine pulse sits at the start of a subperiod and lasts four clocks.
// [RULE15] A fine latch of all zeros adds no fine pulses.
// [RULE16] Fine bit k pulses subperiods with exactly 6-k trailing zero bits.
// [RULE17] Reset loads register reset values and restarts all counting.
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
module mpd_top (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address and data
  input  wire logic [11:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // AXI4-Lite write response
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read
  input  wire logic [11:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Port latch levels used when a pin is not a modulated output
  input  wire logic [10:0] port_latch,
  // Pin levels and function select
  output logic [10:0]      pin_level,
  output logic [10:0]      pin_is_pwm
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic            aw_rdy;
    logic            bvalid;
    logic [1:0]      bresp;
    logic            ar_rdy;
    logic            rvalid;
    logic [31:0]     rdata;
    logic [1:0]      rresp;
    logic [1:0]      presc;
    logic            tick;
    logic [7:0]      fctl;
    logic [7:0]      coarse;
    logic [7:0]      fine;
    logic [7:0]      oe1;
    logic [7:0]      oe2;
    logic [9:0][7:0] duty;
    logic            load;
    logic [10:0]     pin_lvl;
    logic [10:0]     pin_sel;
  } mpd_top_st_t;

  mpd_top_st_t s_r, s_nxt;

  logic [9:0]  narrow_pulse;
  logic        hires_output;
  logic        wr_go;
  logic        rd_go;
  logic        wr_hit;
  logic        rd_hit;
  logic [7:0]  rd_val;
  logic [7:0]  w_idx;
  logic [7:0]  r_idx;
  logic        w_map;
  logic        r_map;
  logic        sel;
  logic        lvl;

  // Handshakes complete while ready is high and the source holds valid
  assign wr_go = s_r.aw_rdy && awvalid && wvalid;
  assign rd_go = s_r.ar_rdy && arvalid;
  assign w_idx = awaddr[9:2];
  assign r_idx = araddr[9:2];
  assign w_map = (awaddr[11:10] == 2'h0);
  assign r_map = (araddr[11:10] == 2'h0);

  ////////////////////////////////////////////////////////////////////////////
  // Channels

  // Ten 8-bit channels
  generate
    for (genvar g = 0; g < mpd_pkg::NARROW_CH; g++) begin : g_narrow
      mpd_narrow_chan u_narrow (
        .aclk    (aclk),
        .aresetn (aresetn),
        .tick    (s_r.tick),
        .duty    (s_r.duty[g]),
        .pulse   (narrow_pulse[g])
      ); // RULE1
    end
  endgenerate

  // The 14-bit channel
  mpd_hires_chan u_hires (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .tick      (s_r.tick),
    .load      (s_r.load),
    .coarse_in (s_r.coarse[6:0]),
    .fine_in   (s_r.fine[6:0]),
    .out       (hires_output)
  ); // RULE1

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  // Read multiplexer
  always_comb begin
    rd_hit = r_map;
    rd_val = 8'h00;
    case (r_idx)
      mpd_pkg::IDX_FCTL:   rd_val = s_r.fctl;
      mpd_pkg::IDX_COARSE: rd_val = s_r.coarse;
      mpd_pkg::IDX_FINE:   rd_val = s_r.fine;
      mpd_pkg::IDX_OE1:    rd_val = s_r.oe1;
      mpd_pkg::IDX_OE2:    rd_val = s_r.oe2;
      default:             rd_hit = 1'b0;
    endcase
    for (int i = 0; i < mpd_pkg::NARROW_CH; i++) begin
      if (r_map && r_idx == mpd_pkg::IDX_DUTY[i]) begin
        rd_hit = 1'b1;
        rd_val = s_r.duty[i];
      end
    end
    if (!r_map) begin
      rd_val = 8'h00;
    end
  end

  // Bus slave, register writes, prescaler and pins
  always_comb begin
    s_nxt      = s_r;
    s_nxt.load = 1'b0;
    wr_hit     = 1'b0;
    sel        = 1'b0;
    lvl        = 1'b0;

    // Quarter-rate tick shared by all counters
    s_nxt.presc = s_r.presc + 2'h1;
    s_nxt.tick  = (s_r.presc == mpd_pkg::PRESC_LAST); // RULE4 RULE11

    // Take address and data together, one write at a time
    s_nxt.aw_rdy = awvalid && wvalid && !s_r.aw_rdy && !s_r.bvalid;
    if (wr_go) begin
      if (w_map) begin
        wr_hit = 1'b1;
        case (w_idx)
          mpd_pkg::IDX_FCTL: begin
            if (wstrb[0]) s_nxt.fctl = wdata[7:0];
          end
          mpd_pkg::IDX_COARSE: begin
            if (wstrb[0]) begin
              s_nxt.coarse = wdata[7:0];
              s_nxt.load   = 1'b1; // RULE7
            end
          end
          mpd_pkg::IDX_FINE: begin
            if (wstrb[0]) s_nxt.fine = wdata[7:0];
          end
          mpd_pkg::IDX_OE1: begin
            if (wstrb[0]) s_nxt.oe1 = wdata[7:0];
          end
          mpd_pkg::IDX_OE2: begin
            if (wstrb[0]) s_nxt.oe2 = wdata[7:0];
          end
          default: wr_hit = 1'b0;
        endcase
        for (int i = 0; i < mpd_pkg::NARROW_CH; i++) begin
          if (w_idx == mpd_pkg::IDX_DUTY[i]) begin
            wr_hit = 1'b1;
            if (wstrb[0]) s_nxt.duty[i] = wdata[7:0];
          end
        end
      end
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = wr_hit ? mpd_pkg::RESP_OKAY : mpd_pkg::RESP_SLVERR;
    end else if (s_r.bvalid && bready) begin
      s_nxt.bvalid = 1'b0;
    end

    // One read at a time, answered the cycle after it is taken
    s_nxt.ar_rdy = arvalid && !s_r.ar_rdy && !s_r.rvalid;
    if (rd_go) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata  = {24'h000000, rd_val};
      s_nxt.rresp  = rd_hit ? mpd_pkg::RESP_OKAY : mpd_pkg::RESP_SLVERR;
    end else if (s_r.rvalid && rready) begin
      s_nxt.rvalid = 1'b0;
    end

    // 8-bit channel pins
    for (int i = 0; i < mpd_pkg::NARROW_CH; i++) begin
      if (i < mpd_pkg::NARROW_IN_OE1) begin
        sel = s_r.oe1[i];
      end else begin
        sel = s_r.oe2[i - mpd_pkg::NARROW_IN_OE1 + mpd_pkg::OE2_CH8_BIT];
      end
      lvl = narrow_pulse[i] ^ s_r.fctl[mpd_pkg::NARROW_POL_BIT]; // RULE3
      s_nxt.pin_sel[i] = sel;
      s_nxt.pin_lvl[i] = sel ? lvl : port_latch[i]; // RULE2
    end

    // 14-bit channel pin
    sel = s_r.oe2[mpd_pkg::HIRES_SEL_BIT];
    lvl = hires_output ^ s_r.fctl[mpd_pkg::WIDE_POL_BIT]; // RULE10
    s_nxt.pin_sel[mpd_pkg::HIRES_IDX] = sel;
    s_nxt.pin_lvl[mpd_pkg::HIRES_IDX] =
      sel ? lvl : port_latch[mpd_pkg::HIRES_IDX]; // RULE6
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register

  // Synchronous reset to documented register values
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r        <= '0;
      s_r.fctl   <= mpd_pkg::FCTL_RST; // RULE17
      s_r.coarse <= mpd_pkg::COARSE_RST;
      s_r.fine   <= mpd_pkg::FINE_RST;
      s_r.oe1    <= mpd_pkg::OE_RST;
      s_r.oe2    <= mpd_pkg::OE_RST;
      s_r.duty   <= {mpd_pkg::NARROW_CH{mpd_pkg::DUTY_RST}};
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state register
  assign awready    = s_r.aw_rdy;
  assign wready     = s_r.aw_rdy;
  assign bvalid     = s_r.bvalid;
  assign bresp      = s_r.bresp;
  assign arready    = s_r.ar_rdy;
  assign rvalid     = s_r.rvalid;
  assign rdata      = s_r.rdata;
  assign rresp      = s_r.rresp;
  assign pin_level  = s_r.pin_lvl;
  assign pin_is_pwm = s_r.pin_sel;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  // Bus answers
  a_write_resp: assert property ( // RULE7
    @(posedge aclk) disable iff (!aresetn)
    (awready && awvalid) |=> bvalid)
    else $error("write not answered");
  a_read_resp: assert property ( // RULE17
    @(posedge aclk) disable iff (!aresetn)
    (arready && arvalid) |=> (rvalid && rdata[31:8] == 24'h000000))
    else $error("read not answered");
  a_bvalid_hold: assert property ( // RULE7
    @(posedge aclk) disable iff (!aresetn)
    (bvalid && !bready) |=> bvalid)
    else $error("write answer dropped early");
  a_rvalid_hold: assert property ( // RULE1
    @(posedge aclk) disable iff (!aresetn)
    (rvalid && !rready) |=> (rvalid && $stable(rdata)))
    else $error("read answer dropped early");
  a_unmapped_err: assert property ( // RULE1
    @(posedge aclk) disable iff (!aresetn)
    (wr_go && !w_map) |=> (bresp == mpd_pkg::RESP_SLVERR))
    else $error("unmapped write not refused");

  // Prescaler and register loads
  a_tick_spacing: assert property ( // RULE11
    @(posedge aclk) disable iff (!aresetn)
    s_r.tick |=> (!s_r.tick [*3] ##1 s_r.tick))
    else $error("tick not every four clocks");
  a_coarse_load: assert property ( // RULE7
    @(posedge aclk) disable iff (!aresetn)
    (wr_go && w_map && w_idx == mpd_pkg::IDX_COARSE && wstrb[0])
      |=> s_r.load ##1 !s_r.load)
    else $error("coarse write did not load once");
  a_fine_noload: assert property ( // RULE7
    @(posedge aclk) disable iff (!aresetn)
    (wr_go && w_idx == mpd_pkg::IDX_FINE) |=> !s_r.load)
    else $error("fine write loaded working latch");
  a_fctl_write: assert property ( // RULE3
    @(posedge aclk) disable iff (!aresetn)
    (wr_go && w_map && w_idx == mpd_pkg::IDX_FCTL && wstrb[0])
      |=> (s_r.fctl == $past(wdata[7:0])))
    else $error("function control not stored");
  a_duty_write: assert property ( // RULE4
    @(posedge aclk) disable iff (!aresetn)
    (wr_go && w_map && w_idx == mpd_pkg::IDX_DUTY[0] && wstrb[0])
      |=> (s_r.duty[0] == $past(wdata[7:0])))
    else $error("duty latch not stored");

  // Pin function select and port fallback
  a_sel_low: assert property ( // RULE2
    @(posedge aclk) disable iff (!aresetn)
    1'b1 |=> (pin_is_pwm[7:0] == $past(s_r.oe1)))
    else $error("low pin select wrong");
  a_sel_upper: assert property ( // RULE2
    @(posedge aclk) disable iff (!aresetn)
    1'b1 |=> (pin_is_pwm[9:8] == $past(s_r.oe2[2:1])))
    else $error("upper pin select wrong");
  a_sel_hires: assert property ( // RULE6
    @(posedge aclk) disable iff (!aresetn)
    1'b1 |=> (pin_is_pwm[10] == $past(s_r.oe2[mpd_pkg::HIRES_SEL_BIT])))
    else $error("hires pin select wrong");
  a_pin_port: assert property ( // RULE2
    @(posedge aclk) disable iff (!aresetn)
    (!s_r.oe1[0]) |=> (pin_level[0] == $past(port_latch[0])))
    else $error("unselected pin not port");
  a_hires_port: assert property ( // RULE6
    @(posedge aclk) disable iff (!aresetn)
    (!s_r.oe2[0]) |=> (pin_level[10] == $past(port_latch[10])))
    else $error("unselected hires pin not port");

  // Polarity
  a_narrow_pol: assert property ( // RULE3
    @(posedge aclk) disable iff (!aresetn)
    s_r.oe1[1] |=> (pin_level[1] ==
      ($past(narrow_pulse[1]) ^ $past(s_r.fctl[mpd_pkg::NARROW_POL_BIT]))))
    else $error("narrow polarity wrong");
  a_hires_pol: assert property ( // RULE10
    @(posedge aclk) disable iff (!aresetn)
    (s_r.oe2[0] && s_r.fctl[0]) |=> (pin_level[10] == !$past(hires_output)))
    else $error("hires polarity wrong");
  a_hires_plain: assert property ( // RULE10
    @(posedge aclk) disable iff (!aresetn)
    (s_r.oe2[0] && !s_r.fctl[0]) |=> (pin_level[10] == $past(hires_output)))
    else $error("hires level inverted");

  // Reset values
  a_reset_vals: assert property ( // RULE17
    @(posedge aclk)
    $rose(aresetn) |-> (s_r.fctl == mpd_pkg::FCTL_RST &&
      s_r.fine == mpd_pkg::FINE_RST))
    else $error("reset values wrong");

endmodule // mpd_top

// ===== mpd_pkg.sv
package mpd_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_FCTL   = 8'hC0;
  localparam logic [7:0] IDX_COARSE = 8'hC6;
  localparam logic [7:0] IDX_FINE   = 8'hC7;
  localparam logic [7:0] IDX_OE1    = 8'hC8;
  localparam logic [7:0] IDX_OE2    = 8'hE8;
  localparam logic [9:0][7:0] IDX_DUTY = {
    8'hEF, 8'hEE, 8'hED, 8'hCF, 8'hCE,
    8'hCD, 8'hCC, 8'hCB, 8'hCA, 8'hC9};

  // Values after reset
  localparam logic [7:0] FCTL_RST   = 8'h80;
  localparam logic [7:0] COARSE_RST = 8'h00;
  localparam logic [7:0] FINE_RST   = 8'h80;
  localparam logic [7:0] OE_RST     = 8'h00;
  localparam logic [7:0] DUTY_RST   = 8'h00;

  // Field positions in function_control and output_enable_second
  localparam int NARROW_POL_BIT = 1;
  localparam int WIDE_POL_BIT   = 0;
  localparam int HIRES_SEL_BIT  = 0;
  localparam int OE2_CH8_BIT    = 1;
  localparam int NARROW_IN_OE1  = 8;

  // Prescaler: counters advance once per four system clocks
  localparam int         PRESC_DIV  = 4;
  localparam logic [1:0] PRESC_LAST = 2'(PRESC_DIV - 1);

  // Channel counts and hires index
  localparam int NARROW_CH = 10;
  localparam int HIRES_IDX = 10;
  localparam int PIN_CNT   = 11;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ===== mpd_narrow_chan.sv
`timescale 1ns/1ps
module mpd_narrow_chan (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Prescaled tick and duty latch
  input  wire logic       tick,
  input  wire logic [7:0] duty,
  // Active-high pulse
  output logic            pulse
);

  typedef struct packed {
    logic [7:0] cnt;
    logic       pulse;
  } mpd_narrow_st_t;

  mpd_narrow_st_t s_r, s_nxt;

  // Count 256 ticks, pulse while count below duty
  always_comb begin
    s_nxt = s_r;
    if (tick) begin
      s_nxt.cnt = s_r.cnt + 8'h01; // RULE5
    end
    s_nxt.pulse = (s_r.cnt < duty); // RULE4
  end

  // State register, restarts at zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0; // RULE17
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pulse = s_r.pulse;

  a_zero_duty: assert property ( // RULE4
    @(posedge aclk) disable iff (!aresetn)
    (duty == 8'h00) |=> !pulse)
    else $error("pulse with zero duty");
  a_count_wrap: assert property ( // RULE5
    @(posedge aclk) disable iff (!aresetn)
    (tick && s_r.cnt == 8'hFF) |=> (s_r.cnt == 8'h00))
    else $error("narrow counter did not wrap");

endmodule // mpd_narrow_chan

// ===== mpd_hires_chan.sv
`timescale 1ns/1ps
module mpd_hires_chan (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Prescaled tick
  input  wire logic       tick,
  // Working latch load from software latches
  input  wire logic       load,
  input  wire logic [6:0] coarse_in,
  input  wire logic [6:0] fine_in,
  // Mixed output before polarity
  output logic            out
);

  typedef struct packed {
    logic [13:0] cnt;
    logic [13:0] work;
    logic        out;
  } mpd_hires_st_t;

  mpd_hires_st_t s_r, s_nxt;
  logic [6:0]    pos;
  logic [6:0]    sub;
  logic [6:0]    one;
  logic          fine_sel;
  logic          coarse_pulse_out;
  logic          fine_pulse_out;

  // Counter, working latch and mixer
  always_comb begin
    s_nxt    = s_r;
    one      = 7'h00;
    fine_sel = 1'b0;
    if (tick) begin
      s_nxt.cnt = s_r.cnt + 14'h0001; // RULE11 RULE12
    end
    if (load) begin
      s_nxt.work = {coarse_in, fine_in}; // RULE7
    end
    pos = s_r.cnt[6:0];
    sub = s_r.cnt[13:7];
    // Bit k picks subperiods with exactly 6-k trailing zeros
    for (int k = 0; k < 7; k++) begin
      one = 7'h01 << (6 - k);
      if (s_r.work[k] && ((sub & ((one << 1) - 7'h01)) == one)) begin
        fine_sel = 1'b1; // RULE16 RULE15
      end
    end
    coarse_pulse_out = (pos < s_r.work[13:7]); // RULE8 RULE13
    fine_pulse_out   = fine_sel && (pos == 7'h00); // RULE14
    s_nxt.out = coarse_pulse_out | fine_pulse_out; // RULE9
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0; // RULE17
    end else begin
      s_r <= s_nxt;
    end
  end

  assign out = s_r.out;

  a_load_work: assert property ( // RULE7
    @(posedge aclk) disable iff (!aresetn)
    load |=> (s_r.work == {$past(coarse_in), $past(fine_in)}))
    else $error("working latch not loaded");
  a_coarse_start: assert property ( // RULE13
    @(posedge aclk) disable iff (!aresetn)
    (s_r.work[13:7] != 7'h00 && s_r.cnt[6:0] == 7'h00) |=> out)
    else $error("no pulse at subperiod start");
  a_fine_width: assert property ( // RULE14
    @(posedge aclk) disable iff (!aresetn)
    (s_r.work[13:7] == 7'h00 && s_r.cnt[6:0] != 7'h00) |=> !out)
    else $error("fine pulse too long");
  a_no_fine: assert property ( // RULE15
    @(posedge aclk) disable iff (!aresetn)
    (s_r.work == 14'h0000) |=> !out)
    else $error("pulse with zero latch");

endmodule // mpd_hires_chan

// ===== mpd_rc_model.sv
`timescale 1ns/1ps
// Integrator stand-in: sums the high time of each pin between clears
module mpd_rc_model (
  // Clock
  input  wire logic              aclk,
  // Discharge request
  input  wire logic              clr,
  // Pin levels from the block
  input  wire logic [10:0]       pin_level,
  // Charge per pin, in system clocks
  output logic      [10:0][16:0] acc
);
  // Charge while high, discharge on request
  always_ff @(posedge aclk) begin
    for (int i = 0; i < 11; i++) begin
      acc[i] <= clr ? 17'h00000 : acc[i] + 17'(pin_level[i]);
    end
  end
endmodule // mpd_rc_model

// ===== mpd_top_bench.sv
`timescale 1ns/1ps
module mpd_top_bench;
  localparam logic [1:0] OK = mpd_pkg::RESP_OKAY;
  localparam logic [1:0] ER = mpd_pkg::RESP_SLVERR;
  logic              aclk, aresetn, clr;
  logic [11:0]       awaddr, araddr;
  logic              awvalid, wvalid, bready, arvalid, rready;
  logic              awready, wready, bvalid, arready, rvalid;
  logic [31:0]       wdata, rdata, seed;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp;
  logic [10:0]       port_latch, pin_level, pin_is_pwm;
  logic [10:0][16:0] acc;
  logic [33:0]       rq[$];
  logic [33:0]       e;
  logic [1:0]        bq[$];
  logic [7:0]        d[10];
  int                n_mismatch, checked, cyc;

  mpd_top dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .port_latch(port_latch), .pin_level(pin_level),
    .pin_is_pwm(pin_is_pwm));
  mpd_rc_model rc_u (.aclk(aclk), .clr(clr), .pin_level(pin_level),
    .acc(acc));

  ////////////////////////////////////////////////////////////////////////
  // Clock, 5 ns period
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // Xorshift source
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Byte address of a register index
  function automatic logic [11:0] ba(input logic [7:0] i);
    return {2'h0, i, 2'h0};
  endfunction

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    chk(34'(rq.size() + bq.size()), 34'h0);
    if (n_mismatch == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Bus cycles; expected answers go to the queues
  task automatic wr(input logic [11:0] a, input logic [7:0] v,
                    input logic [1:0] er);
    bit aw_d, w_d;
    bq.push_back(er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h000000, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_d && w_d)) begin
      @(posedge aclk);
      if (!aw_d && awready) begin
        aw_d = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_d && wready) begin
        w_d = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] v,
                    input logic [1:0] er);
    rq.push_back({er, 24'h000000, v});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask

  // Clear the integrator, then let n clocks of pin levels accumulate
  task automatic meas(input int n);
    @(posedge aclk);
    clr <= 1'b1;
    @(posedge aclk);
    clr <= 1'b0;
    repeat (n) @(posedge aclk);
    #1;
  endtask

  task automatic rst_chk();
    rd(ba(mpd_pkg::IDX_FCTL), mpd_pkg::FCTL_RST, OK);
    rd(ba(mpd_pkg::IDX_COARSE), mpd_pkg::COARSE_RST, OK);
    rd(ba(mpd_pkg::IDX_FINE), mpd_pkg::FINE_RST, OK);
    rd(ba(mpd_pkg::IDX_OE1), 8'h00, OK);
    rd(ba(mpd_pkg::IDX_OE2), 8'h00, OK);
    for (int i = 0; i < 10; i++)
      rd(ba(mpd_pkg::IDX_DUTY[i]), mpd_pkg::DUTY_RST, OK);
    chk(34'(pin_is_pwm), 34'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Watcher: compares each answer with the oldest note
  always @(posedge aclk) begin
    if (rvalid && rready) begin
      if (rq.size() == 0) chk({rresp, rdata}, '1);
      else chk({rresp, rdata}, rq.pop_front());
    end
    if (bvalid && bready) begin
      if (bq.size() == 0) chk(34'(bresp), '1);
      else chk(34'(bresp), 34'(bq.pop_front()));
    end
  end

  // Hang limit
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 90000) begin
      chk(34'(cyc), 34'h0);
      end_sim();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {aresetn, clr, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
    {awaddr, araddr, wdata} = 56'h0;
    wstrb = 4'hF;
    port_latch = 11'h000;
    seed = 32'h6AD2;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rst_chk();
    // Unselected pins follow the port latch
    port_latch <= 11'(xs());
    meas(4);
    chk(34'(pin_level), 34'(port_latch));
    // Duty latches, boundary values first
    for (int i = 0; i < 10; i++) begin
      d[i] = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'(xs());
      wr(ba(mpd_pkg::IDX_DUTY[i]), d[i], OK);
      rd(ba(mpd_pkg::IDX_DUTY[i]), d[i], OK);
    end
    wr(ba(mpd_pkg::IDX_OE1), 8'hFF, OK);
    wr(ba(mpd_pkg::IDX_OE2), 8'h01, OK);
    meas(4);
    chk(34'(pin_is_pwm), 34'h4FF);
    chk(34'(pin_level[9:8]), 34'(port_latch[9:8]));
    wr(ba(mpd_pkg::IDX_OE2), 8'h07, OK);
    // Both narrow polarities over one full period
    for (int p = 0; p < 2; p++) begin
      wr(ba(mpd_pkg::IDX_FCTL), 8'h80 | 8'(p << 1), OK);
      meas(1024);
      for (int i = 0; i < 10; i++) begin
        e = p ? 34'(1024 - 4 * d[i]) : 34'(4 * d[i]);
        chk(34'(acc[i]), e);
      end
      chk(34'(acc[10]), 34'h0);
      chk(34'(pin_is_pwm), 34'h7FF);
    end
    // Coarse only, both polarities over one subperiod
    wr(ba(mpd_pkg::IDX_FCTL), 8'h80, OK);
    wr(ba(mpd_pkg::IDX_COARSE), 8'h20, OK);
    meas(512);
    chk(34'(acc[10]), 34'h80);
    wr(ba(mpd_pkg::IDX_FCTL), 8'h81, OK);
    meas(512);
    chk(34'(acc[10]), 34'h180);
    // Fine write alone must not reach the working latch
    wr(ba(mpd_pkg::IDX_FCTL), 8'h80, OK);
    wr(ba(mpd_pkg::IDX_COARSE), 8'h00, OK);
    wr(ba(mpd_pkg::IDX_FINE), 8'h45, OK);
    meas(512);
    chk(34'(acc[10]), 34'h0);
    // Coarse write loads it; one full frame of fine pulses
    wr(ba(mpd_pkg::IDX_COARSE), 8'h00, OK);
    meas(65536);
    chk(34'(acc[10]), 34'h114);
    // Unmapped places
    rd(12'h000, 8'h00, ER);
    wr(12'h004, 8'h5A, ER);
    rd(12'hC00, 8'h00, ER);
    // Reset in mid-run
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rst_chk();
    repeat (4) @(posedge aclk);
    end_sim();
  end
endmodule // mpd_top_bench
